// [design/ucc_top.v]
// unified 4-way write-through cache controller with register page.
// assumes core, memory port and register port share clk; the core
// holds cpu_req until cpu_ready, the memory holds data until mem_ack.
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defines.vh"

module ucc_top (
  input  wire        clk,
  input  wire        sys_rst,
  // register port
  input  wire        reg_sel,
  input  wire        reg_wr,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  // core side
  input  wire        cpu_req,
  input  wire        cpu_we,
  input  wire        cpu_instr,
  input  wire [31:0] cpu_addr,
  input  wire [3:0]  cpu_be,
  input  wire [31:0] cpu_wdata,
  output reg         cpu_ready,
  output reg  [31:0] cpu_rdata,
  // memory master side
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [3:0]  mem_be,
  output reg  [31:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  // storage clock enable for the array macros, cache status flag and event count
  output reg         ram_clk_en,
  output reg         cache_active_flag,
  output wire [31:0] event_tally
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_FILL  = 3'h1;
  localparam [2:0] ST_WRITE = 3'h2;
  localparam [2:0] ST_PASS  = 3'h3;
  localparam [2:0] ST_RESP  = 3'h4;

  //////////////////////////////////////////////////////////////////////
  // storage: tag directory, line data, per-line valid bits
  reg [`UCC_TAG_W-1:0] tag_mem [0:`UCC_LINES-1];
  reg [31:0]           data_mem [0:`UCC_WORDS-1];
  reg [`UCC_LINES-1:0] line_valid;
  reg [2*`UCC_SETS-1:0] rr_ptr;  // two bits per set

  // control state
  reg        cache_on_bit;
  reg        gating_off_bit;
  reg [1:0]  mon_mode;
  reg        counter_run_bit;
  reg [2:0]  state;
  reg [1:0]  fill_word;
  reg [1:0]  fill_way;
  reg        hit_ipulse;
  reg        hit_dpulse;

  // address split: physical address used directly
  wire [`UCC_TAG_W-1:0] req_tag  = cpu_addr[31:9];
  wire [4:0]            req_set  = cpu_addr[8:4];
  wire [1:0]            req_word = cpu_addr[3:2];

  // register write strobes
  wire wr_any      = reg_sel && reg_wr;
  wire wr_gating   = wr_any && (reg_addr == `UCC_OFS_GATING);
  wire wr_control  = wr_any && (reg_addr == `UCC_OFS_CONTROL);
  wire wr_inv_all  = wr_any && (reg_addr == `UCC_OFS_INV_ALL);
  wire wr_inv_line = wr_any && (reg_addr == `UCC_OFS_INV_LINE);
  wire wr_mcfg     = wr_any && (reg_addr == `UCC_OFS_MON_CONFIG);
  wire wr_men      = wr_any && (reg_addr == `UCC_OFS_MON_ENABLE);
  wire wr_mctrl    = wr_any && (reg_addr == `UCC_OFS_MON_CONTROL);

  wire flush_every_line_bit = wr_inv_all && reg_wdata[`UCC_BIT_FLUSH_ALL];
  wire counter_clear_bit    = wr_mctrl && reg_wdata[`UCC_BIT_COUNTER_CLR];
  wire [1:0] inv_way        = reg_wdata[`UCC_LINE_WAY_RANGE];
  wire [4:0] inv_set        = reg_wdata[`UCC_LINE_IDX_RANGE];

  //////////////////////////////////////////////////////////////////////
  // per-way tag compare
  wire [3:0] way_hit;
  genvar gw;
  generate
    for (gw = 0; gw < `UCC_WAYS; gw = gw + 1) begin : g_way
      wire [6:0] line_no = {req_set, gw[1:0]};
      assign way_hit[gw] = line_valid[line_no] && (tag_mem[line_no] == req_tag);
    end
  endgenerate

  reg [1:0] hit_way;
  always @* begin
    case (way_hit)
      4'h2:    hit_way = 2'h1;
      4'h4:    hit_way = 2'h2;
      4'h8:    hit_way = 2'h3;
      default: hit_way = 2'h0;
    endcase
  end

  wire       any_hit  = |way_hit;
  wire [1:0] victim   = rr_ptr[2*req_set +: 2];
  wire [8:0] hit_word = {req_set, hit_way, req_word};

  // write-hit merge under byte enables
  reg [31:0] merged;
  integer bi;
  always @* begin
    merged = data_mem[hit_word];
    for (bi = 0; bi < 4; bi = bi + 1) begin
      if (cpu_be[bi]) begin
        merged[8*bi +: 8] = cpu_wdata[8*bi +: 8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // configuration registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cache_on_bit    <= `UCC_RST_CACHE_ON;
      gating_off_bit  <= `UCC_RST_GATING;
      mon_mode        <= `UCC_RST_MON_MODE;
      counter_run_bit <= `UCC_RST_MON_RUN;
    end else begin
      if (wr_control) begin
        cache_on_bit <= reg_wdata[`UCC_BIT_CACHE_ON];
      end
      if (wr_gating) begin
        gating_off_bit <= reg_wdata[`UCC_BIT_GATING_OFF];
      end
      if (wr_mcfg) begin
        mon_mode <= reg_wdata[`UCC_MON_MODE_RANGE];
      end
      if (wr_men) begin
        counter_run_bit <= reg_wdata[`UCC_BIT_COUNTER_RUN];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register read-back, one cycle after the request
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_sel && !reg_wr) begin
      case (reg_addr)
        `UCC_OFS_CAPABILITY: reg_rdata <= {18'h0_0000, `UCC_CAP_LINE_16B, `UCC_CAP_SIZE_2KB,
                                           `UCC_CAP_LOCKDOWN, `UCC_CAP_WAYS_4, `UCC_CAP_ROUND_ROBIN,
                                           `UCC_CAP_LRU, `UCC_CAP_RANDOM, `UCC_CAP_DYN_GATING,
                                           `UCC_CAP_DEBUG_PORT};
        `UCC_OFS_GATING:     reg_rdata <= {31'h0000_0000, gating_off_bit};
        `UCC_OFS_STATE:      reg_rdata <= {31'h0000_0000, cache_active_flag};
        `UCC_OFS_MON_CONFIG: reg_rdata <= {30'h0000_0000, mon_mode};
        `UCC_OFS_MON_ENABLE: reg_rdata <= {31'h0000_0000, counter_run_bit};
        `UCC_OFS_MON_COUNT:  reg_rdata <= event_tally;
        default:             reg_rdata <= 32'h0000_0000;  // write-only and reserved
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // valid bits and round robin pointers; maintenance wins over a fill
  // finishing in the same cycle so no stale line survives a flush
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_valid <= {`UCC_LINES{1'b0}};
      rr_ptr     <= {2*`UCC_SETS{1'b0}};
    end else if (flush_every_line_bit) begin
      line_valid <= {`UCC_LINES{1'b0}};
    end else if (wr_inv_line) begin
      line_valid[{inv_set, inv_way}] <= 1'b0;
      rr_ptr[2*inv_set +: 2]         <= inv_way;
    end else if (state == ST_FILL && mem_ack && fill_word == 2'h3) begin
      line_valid[{req_set, fill_way}] <= 1'b1;
      rr_ptr[2*req_set +: 2]          <= fill_way + 2'h1;
    end
  end

  // tag and data arrays carry no reset
  always @(posedge clk) begin
    if (state == ST_FILL && mem_ack) begin
      data_mem[{req_set, fill_way, fill_word}] <= mem_rdata;
      if (fill_word == 2'h3) begin
        tag_mem[{req_set, fill_way}] <= req_tag;
      end
    end else if (state == ST_WRITE && mem_ack && cache_active_flag && any_hit) begin
      data_mem[hit_word] <= merged;  // keeps later hits coherent
    end
  end

  //////////////////////////////////////////////////////////////////////
  // access sequencer; enable changes only take hold between accesses
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state             <= ST_IDLE;
      cache_active_flag <= 1'b0;
      cpu_ready         <= 1'b0;
      cpu_rdata         <= 32'h0000_0000;
      mem_req           <= 1'b0;
      mem_we            <= 1'b0;
      mem_addr          <= 32'h0000_0000;
      mem_be            <= 4'h0;
      mem_wdata         <= 32'h0000_0000;
      fill_word         <= 2'h0;
      fill_way          <= 2'h0;
      hit_ipulse        <= 1'b0;
      hit_dpulse        <= 1'b0;
    end else begin
      cpu_ready  <= 1'b0;
      hit_ipulse <= 1'b0;
      hit_dpulse <= 1'b0;
      case (state)
        ST_IDLE: begin
          cache_active_flag <= cache_on_bit;
          if (cpu_req && cache_on_bit == cache_active_flag) begin
            if (cpu_we) begin
              // every write goes out; misses never allocate
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= cpu_addr;
              mem_be    <= cpu_be;
              mem_wdata <= cpu_wdata;
              state     <= ST_WRITE;
            end else if (!cache_active_flag) begin
              mem_req  <= 1'b1;
              mem_we   <= 1'b0;
              mem_addr <= {cpu_addr[31:2], 2'h0};  // reads are word aligned
              mem_be   <= 4'hF;
              state    <= ST_PASS;
            end else if (any_hit) begin
              cpu_rdata  <= data_mem[hit_word];
              cpu_ready  <= 1'b1;
              hit_ipulse <= cpu_instr;
              hit_dpulse <= !cpu_instr;
              state      <= ST_RESP;
            end else begin
              // line fill from the aligned 16-byte block
              mem_req   <= 1'b1;
              mem_we    <= 1'b0;
              mem_addr  <= {cpu_addr[31:4], 4'h0};
              mem_be    <= 4'hF;
              fill_word <= 2'h0;
              fill_way  <= victim;
              state     <= ST_FILL;
            end
          end
        end
        ST_FILL: begin
          if (mem_ack) begin
            if (fill_word == req_word) begin
              cpu_rdata <= mem_rdata;
            end
            if (fill_word == 2'h3) begin
              mem_req   <= 1'b0;
              cpu_ready <= 1'b1;
              state     <= ST_RESP;
            end else begin
              fill_word <= fill_word + 2'h1;
              mem_addr  <= {cpu_addr[31:4], fill_word + 2'h1, 2'h0};
            end
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            mem_req    <= 1'b0;
            mem_we     <= 1'b0;
            cpu_ready  <= 1'b1;
            hit_dpulse <= cache_active_flag && any_hit;
            state      <= ST_RESP;
          end
        end
        ST_PASS: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            cpu_rdata <= mem_rdata;
            cpu_ready <= 1'b1;
            state     <= ST_RESP;
          end
        end
        ST_RESP: begin
          // core still shows its request this cycle; let it drop
          state <= ST_IDLE;
        end
        default: begin
          state   <= ST_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // array clock enable: gated off when idle unless gating is disabled
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_clk_en <= 1'b0;
    end else begin
      ram_clk_en <= gating_off_bit || cpu_req || (state != ST_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // performance monitor
  ucc_event_counter u_counter (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .counter_run_bit   (counter_run_bit),
    .counter_clear_bit (counter_clear_bit),
    .mode              (mon_mode),
    .ihit              (hit_ipulse),
    .dhit              (hit_dpulse),
    .event_tally       (event_tally)
  );

endmodule
`default_nettype wire

// [shared/ucc_defines.vh]
// constants for the unified cache controller: register offsets,
// field positions, reset values, geometry and capability codes.
// assumes byte offsets within the controller's register page.
`ifndef UCC_DEFINES_VH
`define UCC_DEFINES_VH

// register offsets
`define UCC_OFS_CAPABILITY   8'h00
`define UCC_OFS_GATING       8'h04
`define UCC_OFS_CONTROL      8'h08
`define UCC_OFS_STATE        8'h0C
`define UCC_OFS_INV_ALL      8'h20
`define UCC_OFS_INV_LINE     8'h24
`define UCC_OFS_MON_CONFIG   8'h28
`define UCC_OFS_MON_ENABLE   8'h2C
`define UCC_OFS_MON_CONTROL  8'h30
`define UCC_OFS_MON_COUNT    8'h34

// reset values
`define UCC_RST_GATING       1'h0
`define UCC_RST_CACHE_ON     1'h0
`define UCC_RST_MON_MODE     2'h0
`define UCC_RST_MON_RUN      1'h0
`define UCC_RST_COUNT        32'h0000_0000

// single-bit field positions
`define UCC_BIT_GATING_OFF   0
`define UCC_BIT_CACHE_ON     0
`define UCC_BIT_ACTIVE       0
`define UCC_BIT_FLUSH_ALL    0
`define UCC_BIT_COUNTER_RUN  0
`define UCC_BIT_COUNTER_CLR  0
// multi-bit field ranges
`define UCC_MON_MODE_RANGE   1:0
`define UCC_LINE_WAY_RANGE   31:30
`define UCC_LINE_IDX_RANGE   8:4

// monitor modes
`define UCC_MODE_CYCLES      2'h0
`define UCC_MODE_IHITS       2'h1
`define UCC_MODE_DHITS       2'h2

// capability fields and values
`define UCC_CAP_DEBUG_PORT   1'h0
`define UCC_CAP_DYN_GATING   1'h1
`define UCC_CAP_RANDOM       1'h0
`define UCC_CAP_LRU          1'h0
`define UCC_CAP_ROUND_ROBIN  1'h1
`define UCC_CAP_WAYS_4       2'h2
`define UCC_CAP_LOCKDOWN     1'h0
`define UCC_CAP_SIZE_2KB     3'h1
`define UCC_CAP_LINE_16B     3'h2

// geometry: 2 kbyte, 16 byte lines, 4 ways -> 32 sets
`define UCC_WAYS             4
`define UCC_SETS             32
`define UCC_LINES            128
`define UCC_WORDS            512
`define UCC_TAG_W            23

`endif

// [design/ucc_event_counter.v]
// 32-bit performance event counter with selectable event source.
// assumes hit pulses are one cycle wide and come from the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defines.vh"

module ucc_event_counter (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        counter_run_bit,
  input  wire        counter_clear_bit,
  input  wire [1:0]  mode,
  input  wire        ihit,
  input  wire        dhit,
  output reg  [31:0] event_tally
);

  reg event_sel;

  //////////////////////////////////////////////////////////////////////
  // event selection by monitor mode
  always @* begin
    case (mode)
      `UCC_MODE_CYCLES: event_sel = 1'b1;
      `UCC_MODE_IHITS:  event_sel = ihit;
      `UCC_MODE_DHITS:  event_sel = dhit;
      default:          event_sel = 1'b0;  // mode 3 counts nothing
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // counter; software clear beats a same-cycle event
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_tally <= `UCC_RST_COUNT;
    end else if (counter_clear_bit) begin
      event_tally <= `UCC_RST_COUNT;
    end else if (counter_run_bit && event_sel) begin
      event_tally <= event_tally + 32'h0000_0001;
    end
  end

endmodule
`default_nettype wire

// [verification/ucc_mem_model.sv]
// word-wide memory on the master port of the cache controller
// assumes one outstanding request; slow adds two wait cycles
`timescale 1ns/1ps
`default_nettype none
module ucc_mem_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  output var  logic        mem_ack,
  output var  logic [31:0] mem_rdata
);
  logic [31:0] mem [0:1023];
  logic [1:0]  wait_cnt;
  // fixed fill pattern, mirrored by the bench
  initial for (int j = 0; j < 1024; j++) mem[j] = 32'h5A3C_0000 ^ (j * 32'h0001_0203);
  // ack one word at a time; read data scrambles outside the ack cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'hFFFF_FFFF;
      wait_cnt  <= 2'h0;
    end else if (mem_req && !mem_ack && wait_cnt == 2'h0) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr[11:2]];
      wait_cnt  <= slow ? 2'h2 : 2'h0;
      for (int k = 0; k < 4; k++) if (mem_we && mem_be[k]) mem[mem_addr[11:2]][k*8 +: 8] <= mem_wdata[k*8 +: 8];
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule
`default_nettype wire

// [verification/ucc_top_assertions.sv]
// port checker for the cache controller
// assumes it is bound to ucc_top; control bits are shadowed from writes
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defines.vh"
module ucc_top_assertions (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_sel,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        cpu_req,
  input wire logic        cpu_we,
  input wire logic [31:0] cpu_addr,
  input wire logic [3:0]  cpu_be,
  input wire logic [31:0] cpu_wdata,
  input wire logic        cpu_ready,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0]  mem_be,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic        ram_clk_en,
  input wire logic        cache_active_flag,
  input wire logic [31:0] event_tally
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       on_sh;
  logic       run_sh;
  logic       gate_sh;
  logic [1:0] mode_sh;
  wire        wr       = reg_sel && reg_wr;
  wire        clr_wr   = wr && reg_addr == `UCC_OFS_MON_CONTROL && reg_wdata[0];
  wire        fill_ack = mem_req && mem_ack && !mem_we && cache_active_flag;
  ////////////////////////////////////////////////////////////////////////
  // shadows land on the same edge as the design's own registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_sh   <= 1'b0;
      run_sh  <= 1'b0;
      gate_sh <= 1'b0;
      mode_sh <= 2'h0;
    end else if (wr) begin
      if (reg_addr == `UCC_OFS_CONTROL) on_sh <= reg_wdata[0];
      if (reg_addr == `UCC_OFS_MON_ENABLE) run_sh <= reg_wdata[0];
      if (reg_addr == `UCC_OFS_GATING) gate_sh <= reg_wdata[0];
      if (reg_addr == `UCC_OFS_MON_CONFIG) mode_sh <= reg_wdata[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_reset_clean: assert property ($past(sys_rst) |-> !cache_active_flag && event_tally == 32'h0)
    else $error("state not clean after reset");
  a_write_through: assert property ($rose(cpu_req) && cpu_we |-> ##[1:2] mem_req && mem_we
    && mem_addr == cpu_addr && mem_wdata == cpu_wdata && mem_be == cpu_be) else $error("write not forwarded");
  a_bypass_off: assert property ($rose(cpu_req) && !cpu_we && !on_sh && !cache_active_flag
    |-> ##1 mem_req && !mem_we && mem_addr == {cpu_addr[31:2], 2'h0}) else $error("disabled read not passed");
  a_fill_aligned: assert property ($rose(mem_req) && !mem_we && cache_active_flag
    |-> mem_addr[3:0] == 4'h0 && mem_be == 4'hF) else $error("fill start not line aligned");
  a_fill_order: assert property (fill_ack && mem_addr[3:2] != 2'h3 |=> mem_req
    && mem_addr == $past(mem_addr) + 32'h4) else $error("fill word order broken");
  a_fill_end: assert property (fill_ack && mem_addr[3:2] == 2'h3 |=> !mem_req && cpu_ready)
    else $error("fill not four words");
  a_flag_follows: assert property (on_sh != cache_active_flag && !cpu_req && !mem_req
    |-> ##[1:2] cache_active_flag == on_sh) else $error("status flag lags enable bit");
  a_flag_source: assert property ($changed(cache_active_flag) |-> cache_active_flag == on_sh)
    else $error("status flag moved on its own");
  a_count_cycles: assert property (run_sh && mode_sh == `UCC_MODE_CYCLES && !clr_wr
    |=> event_tally == $past(event_tally) + 32'h1) else $error("cycle count missed");
  a_count_clear: assert property (clr_wr |=> event_tally == 32'h0) else $error("counter not cleared");
  a_count_step: assert property (event_tally != $past(event_tally)
    |-> event_tally == $past(event_tally) + 32'h1 || event_tally == 32'h0) else $error("counter jumped");
  a_gating_off: assert property (gate_sh && $past(gate_sh) |-> ram_clk_en) else $error("array clock gated");
  c_fill: cover property (fill_ack && mem_addr[3:2] == 2'h3);
  c_clear: cover property (clr_wr);
  c_enable: cover property ($rose(cache_active_flag));
endmodule
bind ucc_top ucc_top_assertions u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_be(cpu_be),
  .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .ram_clk_en(ram_clk_en),
  .cache_active_flag(cache_active_flag), .event_tally(event_tally));
`default_nettype wire

// [verification/tb_unified_cache_controller.sv]
// self-checking bench for the cache controller with memory model
// assumes a 50 ns clock; expectations come from a shadow of memory
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defines.vh"
module tb_unified_cache_controller;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_sel = 1'b0;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        cpu_req = 1'b0;
  logic        cpu_we = 1'b0;
  logic        cpu_instr = 1'b0;
  logic [31:0] cpu_addr = 32'h0;
  logic [3:0]  cpu_be = 4'h0;
  logic [31:0] cpu_wdata = 32'h0;
  logic        slow = 1'b0;
  logic        rd_p1 = 1'b0;
  logic        rd_p2 = 1'b0;
  wire  [31:0] reg_rdata, cpu_rdata, mem_addr, mem_wdata, mem_rdata, event_tally;
  wire  [3:0]  mem_be;
  wire         cpu_ready, mem_req, mem_we, mem_ack, ram_clk_en, cache_active_flag;
  logic [31:0] shadow [0:1023];
  logic [32:0] cpu_q [$];
  logic [31:0] reg_q [$];
  logic [32:0] e;
  logic [31:0] r;
  integer      seed = 32'h08efd4ea;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;
  int          words_seen = 0;
  always #25 clk = ~clk;
  ucc_top uut (.clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_instr(cpu_instr),
    .cpu_addr(cpu_addr), .cpu_be(cpu_be), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ram_clk_en(ram_clk_en), .cache_active_flag(cache_active_flag),
    .event_tally(event_tally));
  ucc_mem_model u_mem (.clk(clk), .sys_rst(sys_rst), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle register strobe; for reads d is the expected value
  task automatic reg_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    reg_sel = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = w ? d : 32'h0;
    if (!w) reg_q.push_back(d);
    @(posedge clk);
    #1;
    reg_sel = 1'b0;
  endtask
  task automatic wait_flag(input logic v);
    for (int n = 0; n < 20 && cache_active_flag !== v; n++) @(posedge clk);
    reg_acc(1'b0, `UCC_OFS_STATE, {31'h0, v});
  endtask
  // one core access; words is the expected count of memory read words
  task automatic cpu(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
                     input int words);
    int w0;
    @(posedge clk);
    #1;
    w0 = words_seen;
    cpu_req = 1'b1;
    cpu_we = w;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_be = be;
    cpu_q.push_back({w, shadow[a[11:2]]});
    for (int k = 0; k < 4; k++) if (w && be[k]) shadow[a[11:2]][k*8 +: 8] = d[k*8 +: 8];
    for (int n = 0; n < 60 && cpu_ready !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    cpu_req = 1'b0;
    check({31'h0, cpu_ready}, 32'h1);
    check(32'(words_seen - w0), 32'(words));
  endtask
  function automatic logic [31:0] set_addr(input int k);
    return 32'h30 + 32'(k) * 32'h200;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // read-word count, read pipeline and cycle ceiling
  always @(posedge clk) begin
    if (mem_req && mem_ack && !mem_we) words_seen++;
    rd_p1 <= reg_sel & ~reg_wr;
    rd_p2 <= rd_p1;
    cycles++;
    if (cycles == 30000) begin
      fails++;
      results();
    end
  end
  // outputs settle by the falling edge; oldest note is compared
  always @(negedge clk) begin
    if (cpu_ready === 1'b1) begin
      e = cpu_q.pop_front();
      if (!e[32]) check(cpu_rdata, e[31:0]);
    end
    if (rd_p2) check(reg_rdata, reg_q.pop_front());
  end
  initial begin
    for (int j = 0; j < 1024; j++) shadow[j] = 32'h5A3C_0000 ^ (j * 32'h0001_0203);
    repeat (20) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 16; i++) reg_acc(1'b0, 8'(i * 4), i == 0 ? 32'h0000_1152 : 32'h0);
    reg_acc(1'b1, 8'h10, 32'hFFFF_FFFF);
    reg_acc(1'b1, `UCC_OFS_CAPABILITY, 32'h0);
    reg_acc(1'b0, 8'h10, 32'h0);
    reg_acc(1'b0, `UCC_OFS_CAPABILITY, 32'h0000_1152);
    reg_acc(1'b1, `UCC_OFS_GATING, 32'h1);
    repeat (4) @(posedge clk);
    reg_acc(1'b0, `UCC_OFS_GATING, 32'h1);
    check({31'h0, ram_clk_en}, 32'h1);
    reg_acc(1'b1, `UCC_OFS_GATING, 32'h0);
    // uncached random traffic while counting cycles
    reg_acc(1'b1, `UCC_OFS_MON_ENABLE, 32'h1);
    check({31'h0, ram_clk_en}, 32'h0);
    reg_acc(1'b0, `UCC_OFS_MON_ENABLE, 32'h1);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      slow = r[0];
      cpu_instr = r[1];
      cpu(r[2], {20'h0, r[13:4], 2'h0}, $random(seed), r[17:14], r[2] ? 0 : 1);
    end
    reg_acc(1'b1, `UCC_OFS_MON_ENABLE, 32'h0);
    reg_acc(1'b1, `UCC_OFS_MON_CONTROL, 32'h1);
    reg_acc(1'b0, `UCC_OFS_MON_COUNT, 32'h0);
    // enable after confirming the cache is off, count instruction hits
    wait_flag(1'b0);
    reg_acc(1'b1, `UCC_OFS_CONTROL, 32'h1);
    wait_flag(1'b1);
    reg_acc(1'b1, `UCC_OFS_MON_CONFIG, 32'h1);
    reg_acc(1'b1, `UCC_OFS_MON_ENABLE, 32'h1);
    reg_acc(1'b1, `UCC_OFS_MON_CONTROL, 32'h1);
    reg_acc(1'b0, `UCC_OFS_MON_CONFIG, 32'h1);
    slow = 1'b1;
    cpu_instr = 1'b1;
    for (int i = 0; i < 4; i++) cpu(1'b0, set_addr(i), 32'h0, 4'hF, 4);
    for (int i = 0; i < 4; i++) cpu(1'b0, set_addr(i) + 32'(i * 4), 32'h0, 4'hF, 0);
    cpu(1'b0, set_addr(4), 32'h0, 4'hF, 4);
    for (int i = 1; i < 4; i++) cpu(1'b0, set_addr(i), 32'h0, 4'hF, 0);
    cpu(1'b0, set_addr(0), 32'h0, 4'hF, 4);
    // single line invalidation, way 3 of set 3
    reg_acc(1'b1, `UCC_OFS_CONTROL, 32'h0);
    wait_flag(1'b0);
    reg_acc(1'b1, `UCC_OFS_INV_LINE, 32'hC000_0030);
    reg_acc(1'b1, `UCC_OFS_CONTROL, 32'h1);
    wait_flag(1'b1);
    cpu(1'b0, set_addr(3), 32'h0, 4'hF, 4);
    cpu(1'b0, set_addr(2), 32'h0, 4'hF, 0);
    cpu(1'b1, set_addr(2), $random(seed), 4'h5, 0);
    cpu(1'b0, set_addr(2), 32'h0, 4'hF, 0);
    reg_acc(1'b0, `UCC_OFS_MON_COUNT, 32'd9);
    // data hits: reads and writes of data only
    reg_acc(1'b1, `UCC_OFS_MON_CONFIG, 32'h2);
    reg_acc(1'b1, `UCC_OFS_MON_CONTROL, 32'h1);
    cpu_instr = 1'b0;
    cpu(1'b0, set_addr(2), 32'h0, 4'hF, 0);
    cpu(1'b1, set_addr(0), $random(seed), 4'hF, 0);
    cpu(1'b0, set_addr(0), 32'h0, 4'hF, 0);
    cpu_instr = 1'b1;
    cpu(1'b0, set_addr(3), 32'h0, 4'hF, 0);
    reg_acc(1'b0, `UCC_OFS_MON_COUNT, 32'd3);
    cpu(1'b1, set_addr(5), $random(seed), 4'hF, 0);
    cpu(1'b0, set_addr(5), 32'h0, 4'hF, 4);
    reg_acc(1'b1, `UCC_OFS_INV_ALL, 32'h0);
    cpu(1'b0, set_addr(2), 32'h0, 4'hF, 0);
    reg_acc(1'b1, `UCC_OFS_INV_ALL, 32'h1);
    cpu(1'b0, set_addr(2), 32'h0, 4'hF, 4);
    cpu(1'b0, set_addr(0), 32'h0, 4'hF, 4);
    reg_acc(1'b1, `UCC_OFS_CONTROL, 32'h0);
    wait_flag(1'b0);
    cpu(1'b0, set_addr(2), 32'h0, 4'hF, 1);
    // misses, instruction hits and uncached reads leave the data hit count alone
    check(event_tally, 32'd3);
    repeat (4) @(posedge clk);
    results();
  end
endmodule
`default_nettype wire
